//--- rtl/ctb_pkg.sv
/*
  Shared constants for the one-button countdown timer: clock rates, time
  bases, ringing schedule, register map and mode encoding.
  Assumes a single 20 MHz clock; every slower rate is derived from it.
*/
package ctb_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned TICK_HZ = 8;
  localparam int unsigned TONE_HZ = 2048;
  localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int unsigned TONE_HALF_CYCLES = CLK_HZ / (2 * TONE_HZ);

  // Times in their own units, then in ticks
  localparam int unsigned FAST1_MS = 1000;
  localparam int unsigned FAST2_MS = 5000;
  localparam int unsigned START_MS = 2000;
  localparam int unsigned SLEEP_MS = 45000;
  localparam int unsigned BLINK_ON_MS = 500;
  localparam int unsigned SEC_MS = 1000;
  localparam int unsigned BURST_MS = 10000;
  localparam int unsigned SECOND_BURST_MS = 30000;
  localparam int unsigned GROUP_MS = 1000;
  localparam int unsigned FAST1_T = FAST1_MS * TICK_HZ / MS_PER_S;
  localparam int unsigned FAST2_T = FAST2_MS * TICK_HZ / MS_PER_S;
  localparam int unsigned START_T = START_MS * TICK_HZ / MS_PER_S;
  localparam int unsigned SLEEP_T = SLEEP_MS * TICK_HZ / MS_PER_S;
  localparam int unsigned BLINK_ON_T = BLINK_ON_MS * TICK_HZ / MS_PER_S;
  localparam int unsigned SEC_T = SEC_MS * TICK_HZ / MS_PER_S;
  localparam int unsigned BURST_T = BURST_MS * TICK_HZ / MS_PER_S;
  localparam int unsigned SECOND_BURST_T = SECOND_BURST_MS * TICK_HZ / MS_PER_S;
  localparam int unsigned GROUP_T = GROUP_MS * TICK_HZ / MS_PER_S;
  localparam int unsigned RING_END_T = SECOND_BURST_T + BURST_T;
  localparam int unsigned BEEPS_PER_GROUP = 3;

  localparam logic [6:0] VALUE_MAX = 7'd99;
  localparam logic [5:0] SEC_LAST = 6'd59;
  localparam logic [5:0] SEC_PER_MIN = 6'd60;
  localparam logic [5:0] HALF_MIN_S = 6'd30;
  localparam logic [6:0] HALF_ZONE_MIN = 7'd10;

  // APB map
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam int unsigned ST_MODE_LSB = 0;
  localparam int unsigned ST_VALUE_LSB = 8;
  localparam int unsigned ST_SECONDS_BIT = 16;
  localparam int unsigned ST_HALF_BIT = 17;
  localparam int unsigned ST_LIT_BIT = 18;
  localparam int unsigned ST_BUZZ_BIT = 19;
  localparam int unsigned CF_CFG_LSB = 0;
  localparam int unsigned CF_ONE_BTN_BIT = 2;
  localparam int unsigned CF_TWO_BTN_BIT = 3;
  localparam int unsigned CF_FAST_BIT = 4;
  localparam int unsigned CTRL_BUZZ_EN_BIT = 0;
  localparam logic CTRL_BUZZ_EN_RESET = 1'b1;

  typedef enum logic [2:0] {
    MODE_WAKE, MODE_PROG, MODE_COUNT, MODE_RING, MODE_WAIT, MODE_PDOWN
  } ctb_mode_t;

  typedef enum logic [1:0] {
    CFG_MIN_SEC, CFG_MIN_ONLY, CFG_MIN_HALF, CFG_SECONDS
  } ctb_cfg_t;
endpackage

//--- rtl/ctb_timer.sv
/*
  One-button countdown timer control: button debounce, programming,
  countdown with blinking display, two-burst ringing, wait and power down,
  plus an APB window onto status, configuration and a buzzer enable.
  Assumes all inputs synchronous to clock; LCD drive and relay electrics
  are outside.
*/
// What this block does
// - Buzzer carries a 2048 Hz square tone derived from the clock while sounding.
// - Two straps decode into four configurations, both high meaning seconds mode.
// - Config 1 shows last minute in seconds; config 2 never shows seconds.
// - Config 3 uses half-minute steps from ten to one minute, last minute in seconds.
// - Restore strap high picks one-button variant; low plus bonded button picks two-button.
// - Second fast increment only when the fast-step strap is high.
// - Exactly one of six modes at all times.
// - First press from power down wakes, shows steady 00, then programming.
// - A short press-release in programming adds one minute.
// - Held over one second, value rises four steps per second.
// - With fast option, held over five seconds, eight steps per second.
// - After release, back to single steps; modes may alternate freely.
// - Incrementing past 99 wraps to 00.
// - Reset forces power down from every mode, programming included; two seconds released with non-zero value starts countdown.
// - At 00 with no press for 45 seconds, enter power down.
// - Countdown blinks the display, half second on, half second off.
// - Final minute counts 59 down to 0 seconds, then ringing.
// - In countdown, a hold over one second aborts at 00 to programming, or to wait in the one-button variant.
// - Ringing: ten groups of three beeps, twenty second pause, ten more groups.
// - After the full ringing sequence, value 00 and programming, or wait in the one-button variant.
// - Display blinks while ringing; any press stops it into programming at 00.
// - Power down stops oscillator, blanks display; basic variant has no wait mode.
`timescale 1ns/100ps
module ctb_timer #(
  parameter int unsigned TICK_CYCLES = ctb_pkg::TICK_CYCLES,
  parameter int unsigned TONE_HALF_CYCLES = ctb_pkg::TONE_HALF_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic button,
  input wire logic config_strap_a,
  input wire logic config_strap_b,
  input wire logic restore_option_strap,
  input wire logic fast_step_option_strap,
  input wire logic secondButtonBonded,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic buzzer,
  output logic relay_drive_out,
  output logic oscEnable,
  output logic dispEnable,
  output logic dispLit,
  output logic [6:0] dispValue,
  output logic dispSeconds,
  output logic dispHalf,
  output ctb_pkg::ctb_mode_t mode
);
  import ctb_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int NW = $clog2(TONE_HALF_CYCLES + 1);

  ctb_mode_t mode_q, mode_d;
  logic [TW-1:0] preCnt_q;
  logic [NW-1:0] toneCnt_q;
  logic tick;
  logic btnSample_q, btnDeb_q, btnDeb_d;
  logic [8:0] heldT_q, idleT_q;
  logic [6:0] setVal_q, setVal_d, remMin_q, remMin_d;
  logic [5:0] subSec_q, subSec_d;
  logic [2:0] secT_q, secT_d;
  logic [8:0] ringT_q, ringT_d;
  logic ignore_q, ignore_d;
  logic buzz_q, buzzEn_q, relay_q, osc_q, dEn_q, lit_q, dSec_q, dHalf_q;
  logic [6:0] dVal_q;

  // Configuration and option decode
  wire ctb_cfg_t cfg = ctb_cfg_t'({config_strap_b, config_strap_a});
  wire oneButtonVariant = restore_option_strap;
  wire twoButtonVariant = !restore_option_strap && secondButtonBonded;
  wire hasWait = oneButtonVariant;
  wire fastOpt = fast_step_option_strap;

  // Prescaler: every time base except the tone is a multiple of this tick
  assign tick = (preCnt_q == TW'(TICK_CYCLES - 1));
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) preCnt_q <= '0;
    else preCnt_q <= tick ? '0 : preCnt_q + 1'b1;
  end

  // Two agreeing tick samples make a debounced level
  assign btnDeb_d = (button == btnSample_q) ? button : btnDeb_q;
  wire pressRise = tick && btnDeb_d && !btnDeb_q;
  wire releaseFall = tick && !btnDeb_d && btnDeb_q;

  // Programming step decode
  wire fast1 = btnDeb_q && btnDeb_d && (heldT_q >= 9'(FAST1_T)) && !ignore_q;
  wire fast2 = fast1 && fastOpt && (heldT_q >= 9'(FAST2_T));
  wire fastStep = fast2 || (fast1 && (heldT_q[0] == 1'b0));
  wire shortStep = releaseFall && (heldT_q < 9'(FAST1_T)) && !ignore_q;
  wire doStep = tick && (mode_q == MODE_PROG) && (fastStep || shortStep);
  wire [6:0] stepVal = (setVal_q == VALUE_MAX) ? 7'h00 : setVal_q + 7'h01;
  wire startCount = !btnDeb_q && (idleT_q > 9'(START_T)) && (setVal_q != 7'h00);
  wire sleepNow = !btnDeb_q && (idleT_q > 9'(SLEEP_T));
  wire abortHold = btnDeb_q && (heldT_q >= 9'(FAST1_T)) && !ignore_q;
  wire secDone = (secT_q == 3'(SEC_T - 1));
  wire [2:0] groupPos = 3'(ringT_q % GROUP_T);
  wire inBurst = (ringT_q < 9'(BURST_T)) ||
    ((ringT_q >= 9'(SECOND_BURST_T)) && (ringT_q < 9'(RING_END_T)));
  wire beepSlot = inBurst && !groupPos[0] && (groupPos < 3'(2 * BEEPS_PER_GROUP));
  wire sounding = (mode_q == MODE_RING) && beepSlot && buzzEn_q;
  wire ctb_mode_t afterEnd = hasWait ? MODE_WAIT : MODE_PROG;

  always_comb begin
    mode_d = mode_q;
    setVal_d = setVal_q;
    remMin_d = remMin_q;
    subSec_d = subSec_q;
    secT_d = secT_q;
    ringT_d = ringT_q;
    ignore_d = ignore_q && !releaseFall;
    unique case (mode_q)
      MODE_PDOWN: begin
        if (pressRise) begin
          mode_d = MODE_WAKE;
          setVal_d = 7'h00;
        end
      end
      MODE_WAKE: begin
        if (releaseFall) mode_d = MODE_PROG;
      end
      MODE_PROG: begin
        if (doStep) setVal_d = stepVal;
        if (tick && startCount) begin
          mode_d = MODE_COUNT;
          remMin_d = setVal_q;
          subSec_d = 6'h00;
          secT_d = 3'h0;
        end else if (tick && sleepNow && setVal_q == 7'h00) begin
          mode_d = MODE_PDOWN;
        end
      end
      MODE_COUNT: begin
        if (tick) begin
          secT_d = secDone ? 3'h0 : secT_q + 3'h1;
          if (remMin_q == 7'h00) begin
            mode_d = MODE_RING;
            ringT_d = 9'h000;
          end else if (abortHold) begin
            mode_d = afterEnd;
            setVal_d = 7'h00;
            ignore_d = 1'b1;
          end else if (secDone) begin
            if (cfg == CFG_SECONDS || subSec_q == SEC_LAST) begin
              subSec_d = 6'h00;
              remMin_d = remMin_q - 7'h01;
            end else begin
              subSec_d = subSec_q + 6'h01;
            end
          end
        end
      end
      MODE_RING: begin
        if (tick) begin
          ringT_d = ringT_q + 9'h001;
          if (pressRise) begin
            mode_d = MODE_PROG;
            setVal_d = 7'h00;
            ignore_d = 1'b1;
          end else if (ringT_q == 9'(RING_END_T - 1)) begin
            mode_d = afterEnd;
            setVal_d = 7'h00;
          end
        end
      end
      MODE_WAIT: begin
        if (tick) ringT_d = ringT_q + 9'h001;
        if (pressRise) begin
          mode_d = MODE_PROG;
          setVal_d = 7'h00;
          ignore_d = 1'b1;
        end else if (tick && sleepNow) begin
          mode_d = MODE_PDOWN;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= MODE_PDOWN;
      setVal_q <= 7'h00;
      remMin_q <= 7'h00;
      subSec_q <= 6'h00;
      secT_q <= 3'h0;
      ringT_q <= 9'h000;
      ignore_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      setVal_q <= setVal_d;
      remMin_q <= remMin_d;
      subSec_q <= subSec_d;
      secT_q <= secT_d;
      ringT_q <= ringT_d;
      ignore_q <= ignore_d;
    end
  end

  // Press and idle durations in ticks, saturating
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      btnSample_q <= 1'b0;
      btnDeb_q <= 1'b0;
      heldT_q <= 9'h000;
      idleT_q <= 9'h000;
    end else if (tick) begin
      btnSample_q <= button;
      btnDeb_q <= btnDeb_d;
      heldT_q <= !btnDeb_d ? 9'h000 : heldT_q + {8'h00, heldT_q != 9'h1FF};
      idleT_q <= btnDeb_d || (mode_d != mode_q) ? 9'h000 : idleT_q + {8'h00, idleT_q != 9'h1FF};
    end
  end

  // Tone generator runs only while a beep is due
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      toneCnt_q <= '0;
      buzz_q <= 1'b0;
    end else if (!sounding) begin
      toneCnt_q <= '0;
      buzz_q <= 1'b0;
    end else if (toneCnt_q == NW'(TONE_HALF_CYCLES - 1)) begin
      toneCnt_q <= '0;
      buzz_q <= !buzz_q;
    end else begin
      toneCnt_q <= toneCnt_q + 1'b1;
    end
  end

  // Display image
  wire blinkMode = (mode_q == MODE_COUNT) || (mode_q == MODE_RING) || (mode_q == MODE_WAIT);
  wire [2:0] blinkPhase = (mode_q == MODE_COUNT) ? secT_q : groupPos;
  wire litNow = !blinkMode || (blinkPhase < 3'(BLINK_ON_T));
  wire lastSec = (cfg == CFG_MIN_SEC || cfg == CFG_MIN_HALF) &&
    ((remMin_q == 7'h01 && subSec_q != 6'h00) || remMin_q == 7'h00);
  wire secShow = (cfg == CFG_SECONDS) || lastSec;
  wire [6:0] secVal = (remMin_q == 7'h00) ? 7'h00 : 7'(SEC_PER_MIN - subSec_q);
  wire halfShow = (cfg == CFG_MIN_HALF) && (remMin_q <= HALF_ZONE_MIN) &&
    (remMin_q > 7'h01) && (subSec_q >= HALF_MIN_S);
  wire inCount = (mode_q == MODE_COUNT);
  wire [6:0] valNow = !inCount ? setVal_q : (lastSec ? secVal : remMin_q);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      osc_q <= 1'b0;
      dEn_q <= 1'b0;
      lit_q <= 1'b0;
      dVal_q <= 7'h00;
      dSec_q <= 1'b0;
      dHalf_q <= 1'b0;
      relay_q <= 1'b0;
    end else begin
      osc_q <= (mode_q != MODE_PDOWN);
      dEn_q <= (mode_q != MODE_PDOWN);
      lit_q <= (mode_q != MODE_PDOWN) && litNow;
      dVal_q <= (mode_q == MODE_PDOWN) ? 7'h00 : valNow;
      dSec_q <= inCount && secShow;
      dHalf_q <= inCount && halfShow;
      relay_q <= inCount;
    end
  end

  assign buzzer = buzz_q;
  assign relay_drive_out = relay_q;
  assign oscEnable = osc_q;
  assign dispEnable = dEn_q;
  assign dispLit = lit_q;
  assign dispValue = dVal_q;
  assign dispSeconds = dSec_q;
  assign dispHalf = dHalf_q;
  assign mode = mode_q;

  // APB slave, zero wait states
  wire access = psel && penable;
  wire hitStatus = (paddr == ADDR_STATUS);
  wire hitConfig = (paddr == ADDR_CONFIG);
  wire hitCtrl = (paddr == ADDR_CTRL);
  wire [31:0] statusWord = (32'(mode_q) << ST_MODE_LSB) | (32'(dVal_q) << ST_VALUE_LSB) |
    (32'(dSec_q) << ST_SECONDS_BIT) | (32'(dHalf_q) << ST_HALF_BIT) |
    (32'(lit_q) << ST_LIT_BIT) | (32'(buzz_q) << ST_BUZZ_BIT);
  wire [31:0] configWord = (32'(cfg) << CF_CFG_LSB) | (32'(oneButtonVariant) << CF_ONE_BTN_BIT) |
    (32'(twoButtonVariant) << CF_TWO_BTN_BIT) | (32'(fastOpt) << CF_FAST_BIT);
  wire [31:0] ctrlWord = 32'(buzzEn_q) << CTRL_BUZZ_EN_BIT;
  assign pready = 1'b1;
  assign pslverr = access && !(hitStatus || hitConfig || hitCtrl);
  assign prdata = !access ? 32'h0000_0000 : hitStatus ? statusWord :
    hitConfig ? configWord : hitCtrl ? ctrlWord : 32'h0000_0000;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) buzzEn_q <= CTRL_BUZZ_EN_RESET;
    else if (access && pwrite && hitCtrl) buzzEn_q <= pwdata[CTRL_BUZZ_EN_BIT];
  end

  // Checks
  property p_tone_period;
    @(posedge clock) disable iff (!rst_n)
      $changed(buzz_q) && sounding && $past(sounding) |-> $past(toneCnt_q) == NW'(TONE_HALF_CYCLES - 1);
  endproperty
  a_tone_period: assert property (p_tone_period) else $error("Tone half period wrong");

  property p_cfg_decode;
    @(posedge clock) disable iff (!rst_n)
      (config_strap_a && config_strap_b) |-> cfg == CFG_SECONDS;
  endproperty
  a_cfg_decode: assert property (p_cfg_decode) else $error("Strap decode wrong");

  property p_mode_legal;
    @(posedge clock) disable iff (!rst_n)
      mode_q inside {MODE_WAKE, MODE_PROG, MODE_COUNT, MODE_RING, MODE_WAIT, MODE_PDOWN};
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("Illegal mode");

  property p_wrap;
    @(posedge clock) disable iff (!rst_n)
      doStep && setVal_q == VALUE_MAX |=> setVal_q == 7'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("No wrap past 99");

  property p_no_start_at_zero;
    @(posedge clock) disable iff (!rst_n)
      mode_q == MODE_PROG && setVal_q == 7'h00 |=> mode_q != MODE_COUNT;
  endproperty
  a_no_start_at_zero: assert property (p_no_start_at_zero) else $error("Countdown from 00");

  property p_pdown_dark;
    @(posedge clock) disable iff (!rst_n)
      mode_q == MODE_PDOWN ##1 mode_q == MODE_PDOWN |=> !oscEnable && !dispEnable;
  endproperty
  a_pdown_dark: assert property (p_pdown_dark) else $error("Power down not dark");

  property p_abort;
    @(posedge clock) disable iff (!rst_n)
      tick && mode_q == MODE_COUNT && remMin_q != 7'h00 && abortHold |=>
        mode_q == afterEnd && setVal_q == 7'h00;
  endproperty
  a_abort: assert property (p_abort) else $error("Long hold did not abort");

  property p_buzz_idle;
    @(posedge clock) disable iff (!rst_n)
      mode_q != MODE_RING ##1 mode_q != MODE_RING |-> !buzzer;
  endproperty
  a_buzz_idle: assert property (p_buzz_idle) else $error("Buzzer outside ringing");

  property p_prog_steady;
    @(posedge clock) disable iff (!rst_n)
      mode_q == MODE_PROG |=> dispLit && !dispSeconds;
  endproperty
  a_prog_steady: assert property (p_prog_steady) else $error("Programming display blinks");

  c_count: cover property (@(posedge clock) disable iff (!rst_n)
    mode_q == MODE_PROG ##1 mode_q == MODE_COUNT);
  c_ring: cover property (@(posedge clock) disable iff (!rst_n) $rose(buzzer));
  c_ring_end: cover property (@(posedge clock) disable iff (!rst_n)
    tick && mode_q == MODE_RING && ringT_q == 9'(RING_END_T - 1));
  c_sleep: cover property (@(posedge clock) disable iff (!rst_n)
    mode_q == MODE_PROG ##1 mode_q == MODE_PDOWN);
endmodule

//--- bench/ctb_user_model.sv
/*
  Far-side model: the push button and a listener on the buzzer line.
  Assumes tone half periods are under 8 clocks and that beeps are split
  by longer silences.
*/
`timescale 1ns/100ps
module ctb_user_model (
  input wire logic clock,
  input wire logic buzzer,
  output logic button
);
  logic lastBuzz = 1'h0;
  int still = 0;
  int beeps = 0;
  int halfLen = 0;

  initial button = 1'h0;

  // Clean contact; bounce is left to the debounce logic itself
  task automatic press(input logic lv);
    @(posedge clock);
    button <= lv;
  endtask

  // Pre-edge sampling keeps the count free of races with the design
  always @(posedge clock) begin
    still = still + 1;
    if (buzzer !== lastBuzz) begin
      if (still >= 8)
        beeps = beeps + 1;
      else
        halfLen = still;
      still = 0;
    end
    lastBuzz = buzzer;
  end
endmodule

//--- bench/tb_ctb_timer.sv
/*
  Bench for the countdown timer: APB register checks, then button walks
  through programming, countdown, ringing and power down.
  Assumes a shortened tick of 16 clocks, so one second is 128 clocks.
*/
`timescale 1ns/100ps
module tb_ctb_timer;
  import ctb_pkg::*;
  localparam int TK = 16;
  logic clock = 1'h0;
  logic rst_n;
  logic cfgA, cfgB, restoreStrap, fastStrap, bonded;
  logic psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic button;
  logic [31:0] prdata;
  logic pready, pslverr, buzzer, relay, oscEnable, dispEnable, dispLit, dispSeconds, dispHalf;
  logic [6:0] dispValue;
  ctb_mode_t mode;
  logic [31:0] rd;
  logic er;
  logic seenSec;
  int num_errors = 0;
  int checked = 0;
  int v;
  int b0;

  always #25 clock = ~clock;

  ctb_timer #(.TICK_CYCLES(TK), .TONE_HALF_CYCLES(2)) uut (
    .clock(clock), .rst_n(rst_n), .button(button), .config_strap_a(cfgA),
    .config_strap_b(cfgB), .restore_option_strap(restoreStrap),
    .fast_step_option_strap(fastStrap), .secondButtonBonded(bonded), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .buzzer(buzzer), .relay_drive_out(relay),
    .oscEnable(oscEnable), .dispEnable(dispEnable), .dispLit(dispLit),
    .dispValue(dispValue), .dispSeconds(dispSeconds), .dispHalf(dispHalf), .mode(mode)
  );

  ctb_user_model user (.clock(clock), .buzzer(buzzer), .button(button));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict;
    if (num_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'h1;
    // Only the watchdog ends a wait for the answer
    do
      @(posedge clock);
    while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Polls look half a cycle after the edge, where outputs have settled
  task automatic ticks(input int n);
    repeat (n * TK) @(negedge clock);
  endtask

  task automatic waitMode(input ctb_mode_t m, input int nt);
    for (int n = 0; n < nt * TK && mode !== m; n++) @(negedge clock);
    check("mode", mode, m);
  endtask

  task automatic waitNew(input int nt);
    logic [6:0] old;
    old = dispValue;
    for (int n = 0; n < nt * TK && dispValue === old; n++) @(negedge clock);
    v = dispValue;
  endtask

  task automatic shortPress;
    user.press(1'h1);
    ticks(3);
    user.press(1'h0);
    ticks(4);
  endtask

  task automatic setTo(input int n);
    for (int k = 0; k < 3 && dispValue !== n; k++) shortPress();
  endtask

  task automatic litClocks;
    v = 0;
    repeat (8 * TK) begin
      @(negedge clock);
      v += dispLit;
    end
  endtask

  task automatic wake;
    user.press(1'h1);
    waitMode(MODE_WAKE, 4);
    check("wake value", dispValue, 7'h0);
    user.press(1'h0);
    waitMode(MODE_PROG, 4);
  endtask

  initial begin
    rst_n <= 1'h0;
    {bonded, fastStrap, restoreStrap, cfgB, cfgA} <= 5'h00;
    psel <= 1'h0;
    penable <= 1'h0;
    pwrite <= 1'h0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    repeat (10) @(posedge clock);
    rst_n <= 1'h1;
    @(negedge clock);
    check("asleep", {mode, oscEnable, dispEnable, buzzer}, {MODE_PDOWN, 3'h0});
    @(posedge clock);
    for (int i = 0; i < 32; i++) begin
      {bonded, fastStrap, restoreStrap, cfgB, cfgA} <= i[4:0];
      apb(1'h0, ADDR_CONFIG, 32'h0);
      v = {fastStrap, ~restoreStrap & bonded, restoreStrap, cfgB, cfgA};
      check("config", rd, v);
    end
    apb(1'h0, ADDR_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h1);
    apb(1'h1, 8'h0C, 32'hFFFFFFFF);
    check("unmapped", {rd, er}, {32'h0, 1'h1});
    {bonded, fastStrap, restoreStrap, cfgB, cfgA} <= 5'h08;
    wake();
    litClocks();
    check("steady", v, 8 * TK);
    check("shown", {dispEnable, dispValue}, 8'h80);
    shortPress();
    check("single step", dispValue, 7'h1);
    user.press(1'h1);
    waitNew(12);
    ticks(16);
    check("slow rate", dispValue, v + 8);
    ticks(20);
    waitNew(2);
    ticks(8);
    check("fast rate", dispValue, (v + 8) % 100);
    for (int n = 0; n < 120 * TK && dispValue !== 7'h63; n++) @(negedge clock);
    waitNew(2);
    check("wrap", v, 0);
    for (int n = 0; n < 4 * TK && dispValue !== 7'h2; n++) @(negedge clock);
    user.press(1'h0);
    ticks(4);
    v = dispValue;
    shortPress();
    check("single again", dispValue, v + 1);
    ticks(10);
    check("still set", mode, MODE_PROG);
    waitMode(MODE_COUNT, 8);
    @(negedge clock);
    check("count quiet", {relay, buzzer}, 2'h2);
    litClocks();
    check("blink", v, 4 * TK);
    user.press(1'h1);
    ticks(4);
    check("short hold", mode, MODE_COUNT);
    waitMode(MODE_PROG, 10);
    ticks(1);
    check("abort value", dispValue, 7'h0);
    user.press(1'h0);
    ticks(4);
    setTo(1);
    waitMode(MODE_COUNT, 24);
    for (int n = 0; n < 16 * TK && dispSeconds !== 1'h1; n++) @(negedge clock);
    check("last minute", {dispSeconds, dispValue}, 8'hBB);
    waitMode(MODE_RING, 480);
    b0 = user.beeps;
    ticks(84);
    check("first burst", user.beeps - b0, 30);
    check("tone half", user.halfLen, 2);
    ticks(150);
    check("pause", user.beeps - b0, 30);
    ticks(90);
    check("second burst", user.beeps - b0, 60);
    check("ring end", {mode, dispValue}, {MODE_PROG, 7'h0});
    ticks(330);
    check("idle", mode, MODE_PROG);
    waitMode(MODE_PDOWN, 40);
    @(negedge clock);
    check("blanked", {oscEnable, dispEnable}, 2'h0);
    @(posedge clock);
    cfgA <= 1'h1;
    wake();
    setTo(1);
    waitMode(MODE_COUNT, 24);
    apb(1'h1, ADDR_CTRL, 32'h0);
    seenSec = 1'h0;
    for (int n = 0; n < 500 * TK && mode !== MODE_RING; n++) begin
      @(negedge clock);
      seenSec |= dispSeconds;
    end
    check("no seconds", seenSec, 1'h0);
    b0 = user.beeps;
    litClocks();
    check("ring blink", v, 4 * TK);
    check("muted", user.beeps - b0, 0);
    user.press(1'h1);
    waitMode(MODE_PROG, 4);
    ticks(1);
    check("stopped", {dispValue, buzzer}, 8'h0);
    user.press(1'h0);
    ticks(4);
    check("no step", dispValue, 7'h0);
    {cfgB, cfgA} <= 2'h2;
    setTo(2);
    waitMode(MODE_COUNT, 24);
    ticks(232);
    check("no half", dispHalf, 1'h0);
    ticks(16);
    check("half", dispHalf, 1'h1);
    @(posedge clock);
    restoreStrap <= 1'h1;
    user.press(1'h1);
    waitMode(MODE_WAIT, 12);
    @(negedge clock);
    check("wait value", dispValue, 7'h0);
    litClocks();
    check("wait blink", v, 4 * TK);
    user.press(1'h0);
    ticks(4);
    check("wait kept", mode, MODE_WAIT);
    shortPress();
    check("wait exit", {mode, dispValue}, {MODE_PROG, 7'h0});
    @(posedge clock);
    {cfgB, cfgA} <= 2'h3;
    setTo(1);
    waitMode(MODE_COUNT, 24);
    @(negedge clock);
    check("seconds mode", {dispSeconds, dispValue}, 8'h81);
    waitMode(MODE_RING, 12);
    give_verdict();
  end

  // Tests take about 40000 cycles; this leaves ample margin
  initial begin
    repeat (70000) @(posedge clock);
    num_errors++;
    give_verdict();
  end
endmodule
